/* File: test/scsi_core_control_status_regs_bench.sv */
`timescale 1ns/1ps
`define check(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end
module scsi_core_control_status_regs_bench;
	logic clock, rst_n, host_wr, host_rd, host_rvalid, script_wr, select_exec, sel_active;
	logic [7:0] host_addr, host_wdata, host_rdata, script_addr, script_wdata, rd;
	logic [2:0] select_exec_id, bus_phase, own_id, destination_id, far_id, far_target;
	logic [3:0] max_sync_offset, sync_offset_used;
	logic [1:0] gp_pin_control_out, gp_pin_control_special, gp_special_out, gp_pins_in;
	logic [1:0] gp_pins_out, gp_pins_oe, gp_pullup_en;
	logic block_move_async_in, selection_phase, dma_control_compat, selected_done;
	logic [7:0] first_byte_in, scsi_data_in, bus_ctl_out, bus_ctl_in, selection_id_lines;
	logic [7:0] line_drive;
	logic dma_fifo_empty, test_four_parity_en, single_step_mode, dma_irq_pending;
	logic [6:0] ev, dma_irq_enable;
	int num_errors = 0;
	int checks = 0;
	int i, j;

	scsi_core_control_status_regs u_scsi_core_control_status_regs (
		.clock, .rst_n, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .host_rvalid,
		.script_wr, .script_addr, .script_wdata, .select_exec, .select_exec_id, .max_sync_offset,
		.bus_phase, .sync_offset_used, .gp_pin_control_out, .gp_pin_control_special,
		.gp_special_out, .gp_pins_in, .gp_pins_out, .gp_pins_oe, .gp_pullup_en,
		.block_move_async_in, .first_byte_in, .selection_phase, .dma_control_compat,
		.scsi_data_in, .bus_ctl_out, .bus_ctl_in, .selected_done, .selection_id_lines, .own_id,
		.dma_fifo_empty, .parity_error_event(ev[6]), .test_four_parity_en,
		.bus_fault_event(ev[5]), .abort_request(ev[4]), .single_step_mode, .instr_done(ev[3]),
		.script_irq_event(ev[2]), .illegal_instr_event(ev[0]), .dma_irq_enable,
		.dma_irq_pending, .destination_id
	);
	scsi_far_device u_scsi_far_device (
		.bus_ctl_out, .line_drive, .sel_active, .far_id, .far_target, .bus_ctl_in,
		.selection_id_lines, .scsi_data_in
	);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// ==========================================
	// access tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		host_wr <= ~s;
		script_wr <= s;
		host_addr <= a;
		script_addr <= a;
		host_wdata <= d;
		script_wdata <= d;
		@(posedge clock);
		host_wr <= 1'b0;
		script_wr <= 1'b0;
	endtask
	task automatic host_read(input logic [7:0] a);
		int k;
		@(posedge clock);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge clock);
		host_rd <= 1'b0;
		#1;
		// latency is fixed, but a dead design must not hang the run
		for (k = 0; k < 3 && host_rvalid !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		rd = host_rdata;
		if (host_rvalid !== 1'b1) begin
			$display("unexpected at %0t: read not answered", $time);
			num_errors++;
			report_and_stop();
		end
	endtask
	task automatic pulse_ev(input logic [6:0] m);
		@(posedge clock);
		ev <= m;
		@(posedge clock);
		ev <= 7'h00;
		#1;
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge clock);
		$display("unexpected at %0t: run timed out", $time);
		num_errors++;
		report_and_stop();
	end

	// ==========================================
	// main sequence
	initial begin
		{host_wr, host_rd, script_wr, select_exec, block_move_async_in, selected_done} = '0;
		{selection_phase, dma_control_compat, sel_active, line_drive, first_byte_in} = '0;
		{host_addr, host_wdata, script_addr, script_wdata, select_exec_id, bus_phase} = '0;
		{far_id, max_sync_offset, ev} = '0;
		{gp_pin_control_out, gp_pin_control_special, gp_special_out} = '0;
		// the far party selects our own id
		{gp_pins_in, own_id, far_target, dma_irq_enable} = {2'h3, 3'h1, 3'h1, 7'h7f};
		{dma_fifo_empty, test_four_parity_en, single_step_mode, rst_n} = 4'he;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		`check(gp_pullup_en, 2'h3)
		`check(gp_pins_oe, 2'h0)
		`check(dma_irq_pending, 1'b0)
		host_read(scsi_ctl_pkg::first_byte_received_off);
		`check(rd, scsi_ctl_pkg::first_byte_received_rst)
		host_read(scsi_ctl_pkg::output_control_latch_off);
		`check(rd, scsi_ctl_pkg::output_control_latch_rst)
		// destination id: host write, then a select instruction overrides it
		wr(1'b0, scsi_ctl_pkg::destination_id_off, 8'hff);
		host_read(scsi_ctl_pkg::destination_id_off);
		`check(rd[2:0], 3'h7)
		@(posedge clock);
		select_exec <= 1'b1;
		select_exec_id <= 3'h5;
		@(posedge clock);
		select_exec <= 1'b0;
		#1;
		`check(destination_id, 3'h5)
		// first byte: host write ignored, script write loads
		wr(1'b0, scsi_ctl_pkg::first_byte_received_off, 8'hc3);
		host_read(scsi_ctl_pkg::first_byte_received_off);
		`check(rd, 8'h00)
		wr(1'b1, scsi_ctl_pkg::first_byte_received_off, 8'h5a);
		host_read(scsi_ctl_pkg::first_byte_received_off);
		`check(rd, 8'h5a)
		// two moves in the same phase: the second still captures
		for (i = 0; i < 2; i++) begin
			@(posedge clock);
			block_move_async_in <= 1'b1;
			first_byte_in <= 8'h11 << i;
			@(posedge clock);
			block_move_async_in <= 1'b0;
		end
		host_read(scsi_ctl_pkg::first_byte_received_off);
		`check(rd, 8'h22)
		// selection copies data lines only while compat is clear
		for (i = 0; i < 2; i++) begin
			@(posedge clock);
			dma_control_compat <= i[0];
			far_id <= 3'h6 - i[2:0];
			sel_active <= 1'b1;
			selection_phase <= 1'b1;
			tick(2);
			selection_phase <= 1'b0;
			host_read(scsi_ctl_pkg::first_byte_received_off);
			`check(rd, 8'h42)
		end
		// selector: two ids give a valid id, a lone id leaves valid clear
		for (i = 0; i < 2; i++) begin
			@(posedge clock);
			far_id <= i ? 3'h1 : 3'h5;
			selected_done <= 1'b1;
			@(posedge clock);
			selected_done <= 1'b0;
			host_read(scsi_ctl_pkg::selector_id_off);
			`check(rd & (i ? 8'h80 : 8'hff), i ? 8'h00 : 8'h85)
		end
		sel_active <= 1'b0;
		// latch walks a one through all 8 lines; each host write drives the bus lines and reads back
		for (i = 0; i < 8; i++) begin
			wr(1'b0, scsi_ctl_pkg::output_control_latch_off, 8'h01 << i);
			tick(3);
			`check(bus_ctl_out, 8'h01 << i)
			host_read(scsi_ctl_pkg::bus_control_lines_off);
			`check(rd, 8'h01 << i)
		end
		wr(1'b0, scsi_ctl_pkg::output_control_latch_off, 8'h00);
		line_drive <= 8'h40;
		tick(3);
		host_read(scsi_ctl_pkg::bus_control_lines_off);
		`check(rd, 8'h40)
		// gp pins: live input, written output, special function
		gp_pins_in <= 2'h2;
		host_read(scsi_ctl_pkg::general_purpose_pins_off);
		`check(rd[1:0], 2'h2)
		wr(1'b0, scsi_ctl_pkg::general_purpose_pins_off, 8'h01);
		gp_pin_control_out <= 2'h1;
		gp_pin_control_special <= 2'h2;
		gp_special_out <= 2'h2;
		tick(2);
		#1;
		`check({gp_pins_oe, gp_pins_out, gp_pullup_en}, 6'h3c)
		// offset in effect for every phase and offset code
		for (i = 0; i < 8; i++) begin
			for (j = 0; j < 16; j++) begin
				@(posedge clock);
				bus_phase <= i[2:0];
				max_sync_offset <= j[3:0];
				@(posedge clock);
				#1;
				`check(sync_offset_used, (i < 2 && j <= 8) ? j[3:0] : 4'h0)
			end
		end
		// each event sets its bit; a read clears it and the pending flag
		for (i = 0; i < 7; i++) begin
			if (i != 1) begin
				pulse_ev(7'h01 << i);
				`check(dma_irq_pending, 1'b1)
				host_read(scsi_ctl_pkg::dma_status_off);
				`check(rd, 8'h80 | (8'h01 << i))
				`check(dma_irq_pending, 1'b0)
				tick(12);
				host_read(scsi_ctl_pkg::dma_status_off);
				`check(rd, 8'h80)
				tick(12);
			end
		end
		// masking, parity disable, single step off, fifo holding data
		dma_irq_enable <= 7'h20;
		test_four_parity_en <= 1'b0;
		single_step_mode <= 1'b0;
		dma_fifo_empty <= 1'b0;
		pulse_ev(7'h5d);
		`check(dma_irq_pending, 1'b0)
		host_read(scsi_ctl_pkg::dma_status_off);
		`check(rd, 8'h15)
		tick(12);
		pulse_ev(7'h20);
		`check(dma_irq_pending, 1'b1)
		report_and_stop();
	end
endmodule

/* File: test/scsi_far_device.sv */
`timescale 1ns/1ps
// ==========================================
// far side: other devices on the wired control bus
module scsi_far_device (
	input wire logic [7:0] bus_ctl_out,
	input wire logic [7:0] line_drive,
	input wire logic sel_active,
	input wire logic [2:0] far_id,
	input wire logic [2:0] far_target,
	output logic [7:0] bus_ctl_in,
	output logic [7:0] selection_id_lines,
	output logic [7:0] scsi_data_in
);
	logic [7:0] ids;
	// wired bus: a line reads asserted if any party asserts it
	assign bus_ctl_in = bus_ctl_out | line_drive;
	assign ids = (8'h01 << far_id) | (8'h01 << far_target);
	// terminated lines read deasserted once released
	assign selection_id_lines = sel_active ? ids : 8'h00;
	assign scsi_data_in = sel_active ? ids : 8'h00;
endmodule

/* File: verilog/scsi_core_control_status_regs.sv */
`timescale 1ns/1ps
module scsi_core_control_status_regs (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	input wire logic script_wr,
	input wire logic [7:0] script_addr,
	input wire logic [7:0] script_wdata,
	input wire logic select_exec,
	input wire logic [2:0] select_exec_id,
	input wire logic [3:0] max_sync_offset,
	input wire logic [2:0] bus_phase,
	output logic [3:0] sync_offset_used,
	input wire logic [1:0] gp_pin_control_out,
	input wire logic [1:0] gp_pin_control_special,
	input wire logic [1:0] gp_special_out,
	input wire logic [1:0] gp_pins_in,
	output logic [1:0] gp_pins_out,
	output logic [1:0] gp_pins_oe,
	output logic [1:0] gp_pullup_en,
	input wire logic block_move_async_in,
	input wire logic [7:0] first_byte_in,
	input wire logic selection_phase,
	input wire logic dma_control_compat,
	input wire logic [7:0] scsi_data_in,
	output logic [7:0] bus_ctl_out,
	input wire logic [7:0] bus_ctl_in,
	input wire logic selected_done,
	input wire logic [7:0] selection_id_lines,
	input wire logic [2:0] own_id,
	input wire logic dma_fifo_empty,
	input wire logic parity_error_event,
	input wire logic test_four_parity_en,
	input wire logic bus_fault_event,
	input wire logic abort_request,
	input wire logic single_step_mode,
	input wire logic instr_done,
	input wire logic script_irq_event,
	input wire logic illegal_instr_event,
	input wire logic [6:0] dma_irq_enable,
	output logic dma_irq_pending,
	output logic [2:0] destination_id
);
	// =========================================
	// local signals
	logic [7:0] first_byte_reg;
	logic [7:0] ctl_latch_reg;
	logic [7:0] selector_reg;
	logic [6:0] dma_status_reg;
	logic [6:0] dma_events;
	logic [7:0] bus_sync1_reg;
	logic [7:0] bus_sync2_reg;
	logic [7:0] read_mux;
	logic [7:0] others;
	logic [1:0] gp_out_reg;
	logic dma_status_read;

	assign dma_status_read = host_rd && host_addr == scsi_ctl_pkg::dma_status_off;

	// highest id first, 7 down to 0
	function automatic logic [2:0] top_id(input logic [7:0] lines);
		logic [2:0] id;
		id = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (lines[i]) begin
				id = 3'(i);
			end
		end
		return id;
	endfunction

	function automatic logic [3:0] ones(input logic [7:0] lines);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, lines[i]};
		end
		return n;
	endfunction

	// =========================================
	// synchronous offset selection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync_offset_used <= 4'h0;
		end else if ((bus_phase == scsi_ctl_pkg::phase_data_out
				|| bus_phase == scsi_ctl_pkg::phase_data_in)
				&& max_sync_offset <= scsi_ctl_pkg::max_offset_limit) begin
			sync_offset_used <= max_sync_offset;
		end else begin
			sync_offset_used <= 4'h0;
		end
	end

	// =========================================
	// destination id
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			destination_id <= scsi_ctl_pkg::destination_id_rst;
		end else if (select_exec) begin
			destination_id <= select_exec_id;
		end else if (script_wr && script_addr == scsi_ctl_pkg::destination_id_off) begin
			destination_id <= script_wdata[2:0];
		end else if (host_wr && host_addr == scsi_ctl_pkg::destination_id_off) begin
			destination_id <= host_wdata[2:0];
		end
	end

	// =========================================
	// general purpose pins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gp_out_reg <= 2'h0;
		end else if (script_wr && script_addr == scsi_ctl_pkg::general_purpose_pins_off) begin
			gp_out_reg <= script_wdata[1:0];
		end else if (host_wr && host_addr == scsi_ctl_pkg::general_purpose_pins_off) begin
			gp_out_reg <= host_wdata[1:0];
		end
	end

	// pull-up only while the pin is an input
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gp_pins_out <= 2'h0;
			gp_pins_oe <= 2'h0;
			gp_pullup_en <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				gp_pins_oe[i] <= gp_pin_control_out[i] | gp_pin_control_special[i];
				gp_pins_out[i] <= gp_pin_control_special[i] ? gp_special_out[i] : gp_out_reg[i];
				gp_pullup_en[i] <= ~(gp_pin_control_out[i] | gp_pin_control_special[i]);
			end
		end
	end

	// =========================================
	// first byte received / accumulator
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			first_byte_reg <= scsi_ctl_pkg::first_byte_received_rst;
		end else if (script_wr && script_addr == scsi_ctl_pkg::first_byte_received_off) begin
			first_byte_reg <= script_wdata;
		end else if (block_move_async_in) begin
			first_byte_reg <= first_byte_in;
		end else if (selection_phase && !dma_control_compat) begin
			first_byte_reg <= scsi_data_in;
		end
	end

	// =========================================
	// output control latch
	// host writes here collide with script updates; script wins the cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_latch_reg <= scsi_ctl_pkg::output_control_latch_rst;
		end else if (script_wr && script_addr == scsi_ctl_pkg::output_control_latch_off) begin
			ctl_latch_reg <= script_wdata;
		end else if (host_wr && host_addr == scsi_ctl_pkg::output_control_latch_off) begin
			ctl_latch_reg <= host_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_ctl_out <= 8'h00;
		end else begin
			bus_ctl_out <= ctl_latch_reg;
		end
	end

	// =========================================
	// selector id
	assign others = selection_id_lines & ~(8'h01 << own_id);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			selector_reg <= scsi_ctl_pkg::selector_id_rst;
		end else if (selected_done) begin
			selector_reg[scsi_ctl_pkg::selector_valid_bit] <= ones(selection_id_lines) == 4'h2;
			selector_reg[6:3] <= 4'h0;
			selector_reg[2:0] <= top_id(others);
		end
	end

	// =========================================
	// bus control line synchroniser
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_sync1_reg <= 8'h00;
			bus_sync2_reg <= 8'h00;
		end else begin
			bus_sync1_reg <= bus_ctl_in;
			bus_sync2_reg <= bus_sync1_reg;
		end
	end

	// =========================================
	// dma status, sticky with set over read-clear
	assign dma_events = {
		test_four_parity_en && parity_error_event,
		bus_fault_event,
		abort_request,
		single_step_mode && instr_done,
		script_irq_event,
		1'b0,
		illegal_instr_event
	};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dma_status_reg <= scsi_ctl_pkg::dma_status_rst;
		end else if (dma_status_read) begin
			dma_status_reg <= dma_events;
		end else begin
			dma_status_reg <= dma_status_reg | dma_events;
		end
	end

	// fifo empty stays out of the pending term
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dma_irq_pending <= 1'b0;
		end else if (dma_status_read) begin
			dma_irq_pending <= |(dma_events & dma_irq_enable);
		end else begin
			dma_irq_pending <= |((dma_status_reg | dma_events) & dma_irq_enable);
		end
	end

	// =========================================
	// host read path
	always_comb begin
		read_mux = 8'h00;
		unique case (host_addr)
			scsi_ctl_pkg::destination_id_off: read_mux = {5'h00, destination_id};
			scsi_ctl_pkg::general_purpose_pins_off: read_mux = {6'h00, gp_pins_in};
			scsi_ctl_pkg::first_byte_received_off: read_mux = first_byte_reg;
			scsi_ctl_pkg::output_control_latch_off: read_mux = ctl_latch_reg;
			scsi_ctl_pkg::selector_id_off: read_mux = selector_reg;
			scsi_ctl_pkg::bus_control_lines_off: read_mux = bus_sync2_reg;
			scsi_ctl_pkg::dma_status_off: read_mux = {dma_fifo_empty, dma_status_reg};
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			host_rdata <= 8'h00;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			host_rdata <= host_rd ? read_mux : 8'h00;
		end
	end

	// =========================================
	// checks
	sequence s_dma_status_read;
		host_rd && host_addr == scsi_ctl_pkg::dma_status_off;
	endsequence

	sequence s_quiet;
		dma_events == 7'h00;
	endsequence

	sequence s_enabled_event;
		(dma_events & dma_irq_enable) != 7'h00;
	endsequence

	a_offset_non_data: assert property (@(posedge clock) disable iff (!rst_n)
		(bus_phase != scsi_ctl_pkg::phase_data_out && bus_phase != scsi_ctl_pkg::phase_data_in)
		|=> sync_offset_used == 4'h0)
		else $error("offset used outside data phase");

	a_offset_follow: assert property (@(posedge clock) disable iff (!rst_n)
		(bus_phase == scsi_ctl_pkg::phase_data_in && max_sync_offset <= 4'h8)
		|=> sync_offset_used == $past(max_sync_offset))
		else $error("offset not taken in data phase");

	a_select_id: assert property (@(posedge clock) disable iff (!rst_n)
		select_exec |=> destination_id == $past(select_exec_id))
		else $error("select id not written");

	a_host_fb_ignored: assert property (@(posedge clock) disable iff (!rst_n)
		(host_wr && !script_wr && !block_move_async_in && !(selection_phase && !dma_control_compat))
		|=> $stable(first_byte_reg))
		else $error("first byte changed by host");

	a_fb_capture: assert property (@(posedge clock) disable iff (!rst_n)
		(block_move_async_in && !script_wr) |=> first_byte_reg == $past(first_byte_in))
		else $error("first byte not captured");

	a_ctl_drive: assert property (@(posedge clock) disable iff (!rst_n)
		(host_wr && host_addr == scsi_ctl_pkg::output_control_latch_off && !script_wr)
		|=> ##1 bus_ctl_out == $past(host_wdata, 2))
		else $error("control line not driven from latch");

	a_line_sync: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> ##1 bus_sync2_reg == $past(bus_ctl_in, 2))
		else $error("control line sync depth wrong");

	a_dma_status_clear: assert property (@(posedge clock) disable iff (!rst_n)
		s_dma_status_read ##0 s_quiet |=> dma_status_reg == 7'h00 && !dma_irq_pending)
		else $error("status not cleared by read");

	a_abort_sticky: assert property (@(posedge clock) disable iff (!rst_n)
		abort_request |=> dma_status_reg[scsi_ctl_pkg::aborted_flag_bit])
		else $error("abort flag not set");

	a_parity_gate: assert property (@(posedge clock) disable iff (!rst_n)
		(!test_four_parity_en && !dma_status_read)
		|=> $stable(dma_status_reg[scsi_ctl_pkg::master_parity_error_bit]))
		else $error("parity flag set while disabled");

	a_step_irq: assert property (@(posedge clock) disable iff (!rst_n)
		(single_step_mode && instr_done && dma_irq_enable[3]) |=> dma_irq_pending)
		else $error("single step did not interrupt");

	a_fifo_no_irq: assert property (@(posedge clock) disable iff (!rst_n)
		(dma_status_reg == 7'h00 && dma_events == 7'h00) |=> !dma_irq_pending)
		else $error("fifo empty raised interrupt");

	a_selector_valid: assert property (@(posedge clock) disable iff (!rst_n)
		(selected_done && ones(selection_id_lines) != 4'h2) |=> !selector_reg[7])
		else $error("selector valid without two ids");

	a_gp_reset: assert property (@(posedge clock)
		!rst_n |=> gp_pins_oe == 2'h0 && gp_pullup_en == 2'h3)
		else $error("general pins not inputs after reset");

	a_fb_select: assert property (@(posedge clock) disable iff (!rst_n)
		(selection_phase && !dma_control_compat && !block_move_async_in && !script_wr)
		|=> first_byte_reg == $past(scsi_data_in))
		else $error("selection data not held");

	a_fb_script: assert property (@(posedge clock) disable iff (!rst_n)
		(script_wr && script_addr == scsi_ctl_pkg::first_byte_received_off)
		|=> first_byte_reg == $past(script_wdata))
		else $error("script write to first byte lost");

	a_dest_script: assert property (@(posedge clock) disable iff (!rst_n)
		(script_wr && script_addr == scsi_ctl_pkg::destination_id_off && !select_exec)
		|=> destination_id == $past(script_wdata[2:0]))
		else $error("destination id not written");

	a_gp_drive: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> gp_pins_oe == ($past(gp_pin_control_out) | $past(gp_pin_control_special)))
		else $error("general pin enable wrong");

	a_gp_pullup: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> gp_pullup_en == ~($past(gp_pin_control_out) | $past(gp_pin_control_special)))
		else $error("pull-up not tied to input mode");

	a_gp_live: assert property (@(posedge clock) disable iff (!rst_n)
		(host_rd && host_addr == scsi_ctl_pkg::general_purpose_pins_off)
		|=> host_rdata[1:0] == $past(gp_pins_in))
		else $error("general pins not read live");

	a_fifo_status: assert property (@(posedge clock) disable iff (!rst_n)
		s_dma_status_read |=> host_rdata[scsi_ctl_pkg::dma_fifo_empty_bit] == $past(dma_fifo_empty))
		else $error("fifo empty bit not reported");

	a_selector_two: assert property (@(posedge clock) disable iff (!rst_n)
		(selected_done && ones(selection_id_lines) == 4'h2) |=> selector_reg[7])
		else $error("selector valid missing");

	a_status_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!dma_status_read |=> (dma_status_reg & $past(dma_status_reg)) == $past(dma_status_reg))
		else $error("status bit lost without read");

	a_event_set: assert property (@(posedge clock) disable iff (!rst_n)
		s_enabled_event |=> dma_irq_pending)
		else $error("enabled event did not interrupt");

	a_read_valid: assert property (@(posedge clock) disable iff (!rst_n)
		host_rd |=> host_rvalid)
		else $error("read not answered");
endmodule

/* File: verilog/scsi_ctl_pkg.sv */
package scsi_ctl_pkg;
	// =========================================
	// register offsets
	localparam logic [7:0] destination_id_off = 8'h06;
	localparam logic [7:0] general_purpose_pins_off = 8'h07;
	localparam logic [7:0] first_byte_received_off = 8'h08;
	localparam logic [7:0] output_control_latch_off = 8'h09;
	localparam logic [7:0] selector_id_off = 8'h0a;
	localparam logic [7:0] bus_control_lines_off = 8'h0b;
	localparam logic [7:0] dma_status_off = 8'h0c;
	// =========================================
	// dma status and selector fields
	localparam int dma_fifo_empty_bit = 7;
	localparam int master_parity_error_bit = 6;
	localparam int bus_fault_bit = 5;
	localparam int aborted_flag_bit = 4;
	localparam int single_step_irq_bit = 3;
	localparam int script_irq_bit = 2;
	localparam int illegal_instr_bit = 0;
	localparam int selector_valid_bit = 7;
	// =========================================
	// reset values and offset limit
	localparam logic [7:0] first_byte_received_rst = 8'h00;
	localparam logic [7:0] output_control_latch_rst = 8'h00;
	localparam logic [2:0] destination_id_rst = 3'h0;
	localparam logic [7:0] selector_id_rst = 8'h00;
	localparam logic [6:0] dma_status_rst = 7'h00;
	localparam logic [3:0] max_offset_limit = 4'h8;
	// =========================================
	// information transfer phases, msg c/d i/o
	typedef enum logic [2:0] {
		phase_data_out = 3'b000,
		phase_data_in = 3'b001,
		phase_command = 3'b010,
		phase_status = 3'b011,
		phase_res_out = 3'b100,
		phase_res_in = 3'b101,
		phase_msg_out = 3'b110,
		phase_msg_in = 3'b111
	} phase_t;
endpackage
